// ---- i2ar_pkg.sv ----
/*
 * i2ar_pkg: offsets, field positions, reset values and carrier types
 * for the address and command register block of the bus controller.
 * Assumes a 32-bit register port with byte offsets on 8 address bits.
 */
`default_nettype none
package i2ar_pkg;
  // register offsets
  localparam logic [7:0] OFS_CON  = 8'h00;
  localparam logic [7:0] OFS_TAR  = 8'h04;
  localparam logic [7:0] OFS_SAR  = 8'h08;
  localparam logic [7:0] OFS_HS   = 8'h0c;
  localparam logic [7:0] OFS_DATA = 8'h10;
  // controller_configuration fields
  localparam int CON_MASTER   = 0;
  localparam int CON_SPEED    = 1;
  localparam int CON_SLAVE10  = 3;
  localparam int CON_MASTER10 = 4;
  localparam int CON_RESTART  = 5;
  localparam int CON_SLAVEDIS = 6;
  // bus_destination_address fields
  localparam int TAR_GCSEL    = 10;
  localparam int TAR_SPECIAL  = 11;
  localparam int TAR_MASTER10 = 12;
  // fifo_data_command_port fields
  localparam int CMD_BIT      = 8;
  // speed codes
  localparam logic [1:0] SPEED_STD  = 2'h1;
  localparam logic [1:0] SPEED_FAST = 2'h2;
  localparam logic [1:0] SPEED_HIGH = 2'h3;
  // reset values
  localparam logic [9:0] DEF_TAR    = 10'h055;
  localparam logic [9:0] DEF_SAR    = 10'h055;
  localparam logic [2:0] DEF_HS     = 3'h1;
  // special addresses
  localparam logic [4:0] HS_PREFIX  = 5'h01;
  localparam logic [9:0] GC_ADDR    = 10'h000;
  localparam logic [9:0] SBYTE_ADDR = 10'h001;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } i2ar_apb_req_t;

  typedef struct packed {
    logic [9:0] tar;
    logic       master10;
    logic       special;
    logic       gcsel;
    logic [9:0] sar;
    logic       slave10;
    logic       slave_dis;
    logic [1:0] speed;
    logic [2:0] hs_code;
  } i2ar_link_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } i2ar_apb_st_t;
endpackage
`default_nettype wire

// ---- i2ar_regs.sv ----
/*
 * i2ar_regs: address and command registers of the bus controller, with
 * the register port, the data/command push and pop, and the link-side
 * address logic running on the link clock.
 * Assumes the enable register, status, fifos and bus engine live outside;
 * their signals arrive on ref_clk, the link engine's on link_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module i2ar_regs
  import i2ar_pkg::*;
#(
  parameter bit         LIVE_DEST   = 1'b1,
  parameter logic [1:0] MAX_SPEED   = i2ar_pkg::SPEED_HIGH,
  parameter bit         MASTER_DEF  = 1'b1,
  parameter bit         SLAVE_OFF   = 1'b1,
  parameter bit         RESTART_DEF = 1'b1,
  parameter bit         SLAVE10_DEF = 1'b1,
  parameter bit         MASTER10_DEF = 1'b1
) (
  // clock and reset
  input  wire  logic                     ref_clk,
  input  wire  logic                     reset,
  // register port
  input  wire  i2ar_pkg::i2ar_apb_req_t  apb_req,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // controller state
  input  wire  logic                     controller_enable,
  input  wire  logic                     master_active,
  input  wire  logic                     tx_fifo_empty,
  input  wire  logic                     tx_fifo_full,
  input  wire  logic                     rx_fifo_valid,
  input  wire  logic [7:0]               rx_byte,
  input  wire  logic                     rd_req_seen,
  // fifo and event outputs
  output logic                           tx_push,
  output logic [8:0]                     tx_entry,
  output logic                           rx_pop,
  output logic                           transmit_abort_event,
  output logic                           master_en,
  output logic                           slave_off,
  output logic                           restart_en,
  // link side
  input  wire  logic                     link_clk,
  input  wire  logic                     lk_addr_stb,
  input  wire  logic [9:0]               lk_addr,
  input  wire  logic                     lk_addr_ten,
  input  wire  logic                     lk_own_master,
  output logic [9:0]                     lk_master_addr,
  output logic                           lk_master_ten,
  output logic [7:0]                     lk_hs_byte,
  output logic [1:0]                     lk_speed,
  output logic                           lk_slave_hit,
  output logic                           lk_loopback
);
  import i2ar_pkg::*;

  localparam bit HS_OK = (MAX_SPEED == SPEED_HIGH);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  function automatic logic [1:0] speed_fix(input logic [1:0] w);
    speed_fix = (w == 2'h0 || w > MAX_SPEED) ? MAX_SPEED : w;
  endfunction

  i2ar_apb_st_t st_r, st_nxt;
  logic [6:0]   con_r;
  logic [9:0]   tar_r;
  logic         tar_m10_r, special_r, gcsel_r;
  logic [9:0]   sar_r;
  logic [2:0]   hs_r;
  logic [31:0]  prdata_r;
  logic         pready_r, pslverr_r, tx_push_r, rx_pop_r, abort_r;
  logic [8:0]   tx_entry_r;

  // register port decode
  wire take    = (st_r == ST_IDLE) & apb_req.psel & apb_req.penable;
  wire wr      = take & apb_req.pwrite;
  wire rd      = take & ~apb_req.pwrite;
  wire s_con   = hit(apb_req.paddr, OFS_CON);
  wire s_tar   = hit(apb_req.paddr, OFS_TAR);
  wire s_sar   = hit(apb_req.paddr, OFS_SAR);
  wire s_hs    = hit(apb_req.paddr, OFS_HS);
  wire s_data  = hit(apb_req.paddr, OFS_DATA);
  wire mapped  = s_con | s_tar | s_sar | s_hs | s_data;
  wire [31:0] wd = apb_req.pwdata;

  // write permissions
  wire dis      = ~controller_enable;
  wire con_ok   = dis;
  wire live_ok  = ~master_active & con_r[CON_MASTER] & tx_fifo_empty;
  wire tar_ok   = LIVE_DEST ? (dis | live_ok) : dis;
  wire hs_ok    = dis & HS_OK;

  // data/command port
  wire cmd_rd   = wd[CMD_BIT];
  wire gc_mode  = special_r & ~gcsel_r & con_r[CON_MASTER];
  wire abort_c  = cmd_rd & (gc_mode | rd_req_seen);
  wire push_c   = wr & s_data & ~abort_c & ~tx_fifo_full;
  wire [8:0] ent_c = cmd_rd ? {1'b1, 8'h00} : {1'b0, wd[7:0]};

  // read mux
  wire m10_eff  = LIVE_DEST ? tar_m10_r : con_r[CON_MASTER10];
  wire [31:0] rd_con  = {25'h0, con_r[6:5], m10_eff, con_r[3:0]};
  wire [31:0] rd_tar  = {19'h0, LIVE_DEST & tar_m10_r, special_r,
                         gcsel_r, tar_r};
  wire [31:0] rd_sar  = {22'h0, sar_r};
  wire [31:0] rd_hs   = {29'h0, HS_OK ? hs_r : 3'h0};
  wire [31:0] rd_data = {24'h0, rx_byte};
  wire [31:0] rd_mux  = s_con ? rd_con : s_tar ? rd_tar :
                        s_sar ? rd_sar : s_hs ? rd_hs :
                        s_data ? rd_data : 32'h0;

  always_comb begin
    st_nxt = ST_IDLE;
    case (st_r)
      ST_IDLE: st_nxt = take ? ST_RESP : ST_IDLE;
      ST_RESP: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r      <= ST_IDLE;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      st_r      <= st_nxt;
      pready_r  <= take;
      pslverr_r <= take & ~mapped;
      prdata_r  <= rd ? rd_mux : 32'h0;
    end
  end

  // controller_configuration
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      con_r <= {SLAVE_OFF, RESTART_DEF, MASTER10_DEF, SLAVE10_DEF,
                MAX_SPEED, MASTER_DEF};
    end else if (wr & s_con & con_ok) begin
      con_r <= {wd[6:5], LIVE_DEST ? con_r[4] : wd[4], wd[3],
                speed_fix(wd[2:1]), wd[0]};
    end
  end

  // bus_destination_address
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tar_r     <= DEF_TAR;
      tar_m10_r <= MASTER10_DEF;
      special_r <= 1'b0;
      gcsel_r   <= 1'b0;
    end else if (wr & s_tar & tar_ok) begin
      tar_r     <= wd[9:0];
      tar_m10_r <= LIVE_DEST ? wd[TAR_MASTER10] : MASTER10_DEF;
      special_r <= wd[TAR_SPECIAL];
      gcsel_r   <= wd[TAR_GCSEL];
    end
  end

  // own_slave_address and high_speed_master_code
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sar_r <= DEF_SAR;
      hs_r  <= DEF_HS;
    end else begin
      if (wr & s_sar & dis)
        sar_r <= wd[9:0];
      if (wr & s_hs & hs_ok)
        hs_r <= wd[2:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_push_r  <= 1'b0;
      tx_entry_r <= 9'h0;
      rx_pop_r   <= 1'b0;
      abort_r    <= 1'b0;
    end else begin
      tx_push_r  <= push_c;
      tx_entry_r <= push_c ? ent_c : tx_entry_r;
      rx_pop_r   <= rd & s_data & rx_fifo_valid;
      abort_r    <= wr & s_data & abort_c;
    end
  end

  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign tx_push              = tx_push_r;
  assign tx_entry             = tx_entry_r;
  assign rx_pop               = rx_pop_r;
  assign transmit_abort_event = abort_r;
  assign master_en            = con_r[CON_MASTER];
  assign slave_off            = con_r[CON_SLAVEDIS];
  assign restart_en           = con_r[CON_RESTART];

  // configuration crossing: snapshot held until link acknowledges
  i2ar_link_cfg_t cfg_live, snap_r, lk_cfg_r;
  logic req_r, ack_m_r, ack_s_r;
  logic lk_rst_m_r, lk_rst_r, req_m_r, req_s_r, req_d_r, ack_r;

  assign cfg_live = '{tar: tar_r, master10: m10_eff, special: special_r,
                      gcsel: gcsel_r, sar: sar_r, slave10: con_r[CON_SLAVE10],
                      slave_dis: con_r[CON_SLAVEDIS],
                      speed: con_r[2:1], hs_code: rd_hs[2:0]};
  wire idle_x = (req_r == ack_s_r);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      snap_r  <= '0;
      req_r   <= 1'b0;
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
    end else begin
      ack_m_r <= ack_r;
      ack_s_r <= ack_m_r;
      if (idle_x && snap_r != cfg_live) begin
        snap_r <= cfg_live;
        req_r  <= ~req_r;
      end
    end
  end

  // link domain
  always_ff @(posedge link_clk) begin
    lk_rst_m_r <= reset;
    lk_rst_r   <= lk_rst_m_r;
  end

  always_ff @(posedge link_clk) begin
    if (lk_rst_r) begin
      req_m_r  <= 1'b0;
      req_s_r  <= 1'b0;
      req_d_r  <= 1'b0;
      ack_r    <= 1'b0;
      lk_cfg_r <= '0;
    end else begin
      req_m_r <= req_r;
      req_s_r <= req_m_r;
      req_d_r <= req_s_r;
      if (req_s_r != req_d_r) begin
        lk_cfg_r <= snap_r;
        ack_r    <= req_s_r;
      end
    end
  end

  wire [9:0] m_addr = ~lk_cfg_r.special ? lk_cfg_r.tar :
                      lk_cfg_r.gcsel ? SBYTE_ADDR : GC_ADDR;
  wire hit7  = ~lk_addr_ten & (lk_addr[6:0] == lk_cfg_r.sar[6:0]);
  wire hit10 = lk_addr_ten & (lk_addr == lk_cfg_r.sar);
  wire s_hit = lk_addr_stb & ~lk_cfg_r.slave_dis & ~lk_own_master &
               (lk_cfg_r.slave10 ? hit10 : hit7);
  wire same  = lk_cfg_r.master10 ? (lk_cfg_r.tar == lk_cfg_r.sar)
                                 : (lk_cfg_r.tar[6:0] == lk_cfg_r.sar[6:0]);

  always_ff @(posedge link_clk) begin
    if (lk_rst_r) begin
      lk_master_addr <= DEF_TAR;
      lk_master_ten  <= 1'b0;
      lk_hs_byte     <= 8'h0;
      lk_speed       <= SPEED_STD;
      lk_slave_hit   <= 1'b0;
      lk_loopback    <= 1'b0;
    end else begin
      lk_master_addr <= m_addr;
      lk_master_ten  <= lk_cfg_r.master10 & ~lk_cfg_r.special;
      lk_hs_byte     <= {HS_PREFIX, lk_cfg_r.hs_code};
      lk_speed       <= lk_cfg_r.speed;
      lk_slave_hit   <= s_hit;
      lk_loopback    <= same & ~lk_cfg_r.slave_dis;
    end
  end

  a_speed_clamp_store: assert property (@(posedge ref_clk) disable iff (reset)
    wr & s_con & dis & (wd[2:1] == 2'h0 || wd[2:1] > MAX_SPEED)
    |=> con_r[2:1] == MAX_SPEED)
    else $error("illegal speed not clamped");
  a_con_write_lock: assert property (@(posedge ref_clk) disable iff (reset)
    wr & s_con & controller_enable |=> $stable(con_r))
    else $error("control changed while enabled");
  a_tar_write_lock: assert property (@(posedge ref_clk) disable iff (reset)
    wr & s_tar & controller_enable & (master_active | tx_fifo_empty == 1'b0)
    |=> $stable(tar_r) && $stable(special_r))
    else $error("target changed while busy");
  a_gc_read_abort: assert property (@(posedge ref_clk) disable iff (reset)
    wr & s_data & wd[CMD_BIT] & gc_mode |=> transmit_abort_event && !tx_push)
    else $error("general call read not aborted");
  a_rdreq_cmd_abort: assert property (@(posedge ref_clk) disable iff (reset)
    wr & s_data & wd[CMD_BIT] & rd_req_seen |=> transmit_abort_event)
    else $error("command after read request not aborted");
  a_read_cmd_payload: assert property (@(posedge ref_clk) disable iff (reset)
    tx_push & tx_entry[CMD_BIT] |-> tx_entry[7:0] == 8'h00)
    else $error("read command carries payload");
  a_hs_code_read: assert property (@(posedge ref_clk) disable iff (reset)
    rd & s_hs |=> prdata[31:3] == 29'h0 && (HS_OK || prdata == 32'h0))
    else $error("master code read wrong");
  a_reserved_reads_zero: assert property (@(posedge ref_clk) disable iff (reset)
    rd & (s_data | s_sar) |=> prdata[31:10] == 22'h0)
    else $error("reserved bits read nonzero");
  a_apb_ready_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    take |=> pready ##1 !pready)
    else $error("ready not one cycle");
  a_slave_off_quiet: assert property (@(posedge link_clk) disable iff (lk_rst_r)
    lk_cfg_r.slave_dis |=> !lk_slave_hit)
    else $error("slave answered while disabled");
  a_no_self_hit: assert property (@(posedge link_clk) disable iff (lk_rst_r)
    lk_addr_stb & lk_own_master |=> !lk_slave_hit)
    else $error("master addressed itself");
  a_seven_bit_match: assert property (@(posedge link_clk) disable iff (lk_rst_r)
    lk_addr_stb & ~lk_cfg_r.slave10 & lk_addr_ten |=> !lk_slave_hit)
    else $error("ten-bit address hit in seven-bit mode");

  c_gc_abort:    cover property (@(posedge ref_clk) disable iff (reset)
    wr & s_data & gc_mode ##1 transmit_abort_event);
  c_live_tar:    cover property (@(posedge ref_clk) disable iff (reset)
    wr & s_tar & controller_enable & live_ok);
  c_speed_clamp: cover property (@(posedge ref_clk) disable iff (reset)
    wr & s_con & dis & wd[2:1] == 2'h0);
  c_slave_hit:   cover property (@(posedge link_clk) disable iff (lk_rst_r)
    lk_slave_hit);
endmodule
`default_nettype wire

// ---- i2ar_bus_agent.sv ----
/*
 * i2ar_bus_agent: link-side stand-in for the other bus parties; presents
 * received addresses on the link clock and reports the slave-hit answer.
 * Assumes the bench makes link_clk and calls the tasks below.
 */
`timescale 1ns/1ps
`default_nettype none
module i2ar_bus_agent (
  // link clock and answer
  input  wire logic       link_clk,
  input  wire logic       lk_slave_hit,
  // received address
  output logic            lk_addr_stb,
  output logic [9:0]      lk_addr,
  output logic            lk_addr_ten,
  output logic            lk_own_master
);
  initial begin
    lk_addr_stb   = 1'b0;
    lk_addr       = 10'h000;
    lk_addr_ten   = 1'b0;
    lk_own_master = 1'b0;
  end

  // one-cycle address strobe, then the lines no longer hold the address
  task automatic send(input logic [9:0] a, input logic t, output logic hit);
    @(posedge link_clk);
    lk_addr_stb <= 1'b1;
    lk_addr     <= a;
    lk_addr_ten <= t;
    @(posedge link_clk);
    lk_addr_stb <= 1'b0;
    lk_addr     <= ~a;
    lk_addr_ten <= ~t;
    @(negedge link_clk);
    hit = lk_slave_hit;
  endtask

  // own master driving the transfer
  task automatic own(input logic v);
    @(posedge link_clk);
    lk_own_master <= v;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
/*
 * tb: self-checking bench for i2ar_regs; register accesses, controller
 * state and link-side address traffic, with expected values per access.
 * Assumes i2ar_pkg and i2ar_bus_agent are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import i2ar_pkg::*;
  logic                ref_clk, reset, link_clk;
  i2ar_apb_req_t       apb_req;
  logic [31:0]         prdata, q, prdata2, q2;
  logic                pready, pslverr, err, push, abrt, pop, hit;
  logic                controller_enable, master_active, tx_fifo_empty;
  logic                tx_fifo_full, rx_fifo_valid, rd_req_seen;
  logic [7:0]          rx_byte, lk_hs_byte;
  logic                tx_push, rx_pop, transmit_abort_event;
  logic                master_en, slave_off, restart_en;
  logic [8:0]          tx_entry, ent;
  logic                lk_addr_stb, lk_addr_ten, lk_own_master;
  logic                lk_master_ten, lk_slave_hit, lk_loopback;
  logic [9:0]          lk_addr, lk_master_addr;
  logic [1:0]          lk_speed, s, sp;
  int                  num_errors, comparisons;

  i2ar_regs dut (.ref_clk, .reset, .apb_req, .prdata, .pready, .pslverr,
    .controller_enable, .master_active, .tx_fifo_empty, .tx_fifo_full,
    .rx_fifo_valid, .rx_byte, .rd_req_seen, .tx_push, .tx_entry, .rx_pop,
    .transmit_abort_event, .master_en, .slave_off, .restart_en, .link_clk,
    .lk_addr_stb, .lk_addr, .lk_addr_ten, .lk_own_master, .lk_master_addr,
    .lk_master_ten, .lk_hs_byte, .lk_speed, .lk_slave_hit, .lk_loopback);

  // second build: static target width, no high-speed master code
  i2ar_regs #(.LIVE_DEST(1'b0), .MAX_SPEED(SPEED_FAST)) dut2 (.ref_clk,
    .reset, .apb_req, .prdata(prdata2), .pready(), .pslverr(),
    .controller_enable, .master_active, .tx_fifo_empty, .tx_fifo_full,
    .rx_fifo_valid, .rx_byte, .rd_req_seen, .tx_push(), .tx_entry(),
    .rx_pop(), .transmit_abort_event(), .master_en(), .slave_off(),
    .restart_en(), .link_clk, .lk_addr_stb, .lk_addr, .lk_addr_ten,
    .lk_own_master, .lk_master_addr(), .lk_master_ten(), .lk_hs_byte(),
    .lk_speed(), .lk_slave_hit(), .lk_loopback());

  i2ar_bus_agent agent (.link_clk, .lk_slave_hit, .lk_addr_stb, .lk_addr,
    .lk_addr_ten, .lk_own_master);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #6 link_clk = ~link_clk;
  end

  task automatic chk(input string nm, input logic [31:0] sn,
                     input logic [31:0] e);
    comparisons++;
    if (sn !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, sn);
    end
  endtask

  task automatic results();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one access: setup, enable held until pready, outputs taken there
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    chk("pready", pready, 32'h1);
    q    = prdata;
    q2   = prdata2;
    err  = pslverr;
    push = tx_push;
    abrt = transmit_abort_event;
    pop  = rx_pop;
    ent  = tx_entry;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("prdata", q, e);
  endtask
  // config crosses to the link domain
  task automatic lk_wait();
    repeat (24) @(posedge ref_clk);
  endtask
  task automatic sl(input logic [9:0] a, input logic t, input logic e);
    agent.send(a, t, hit);
    chk("lk_slave_hit", hit, e);
    // back onto a ref_clk edge before the next drive
    @(posedge ref_clk);
  endtask

  initial begin
    #100000;
    num_errors++;
    results();
  end

  initial begin
    apb_req = '0;
    reset = 1'b1;
    controller_enable = 1'b0;
    master_active = 1'b0;
    tx_fifo_empty = 1'b1;
    tx_fifo_full = 1'b0;
    rx_fifo_valid = 1'b0;
    rx_byte = 8'h5a;
    rd_req_seen = 1'b0;
    num_errors = 0;
    comparisons = 0;
    // two cycles; the link side synchronises it
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    lk_wait();
    chk("master_en", master_en, 32'h1);
    rd(OFS_CON, 32'h7f);
    chk("pslverr", err, 32'h0);
    rd(OFS_TAR, 32'h1055);
    chk("prdata2", q2, 32'h055);
    rd(OFS_SAR, 32'h055);
    rd(OFS_HS, 32'h1);
    chk("prdata2", q2, 32'h0);
    chk("lk_hs_byte", lk_hs_byte, 32'h09);
    chk("lk_master_ten", lk_master_ten, 32'h1);
    for (int i = 0; i < 4; i++) begin
      s  = 2'((i + 2) % 4);
      sp = (s == 2'h0) ? SPEED_HIGH : s;
      wr(OFS_CON, 32'hffffff80 | (32'(s) << 1));
      rd(OFS_CON, 32'h10 | (32'(sp) << 1));
    end
    lk_wait();
    chk("lk_speed", lk_speed, 32'h1);
    chk("master_en", master_en, 32'h0);
    chk("restart_en", restart_en, 32'h0);
    wr(OFS_SAR, 32'h3a5);
    rd(OFS_SAR, 32'h3a5);
    wr(OFS_HS, 32'hffffffff);
    rd(OFS_HS, 32'h7);
    chk("prdata2", q2, 32'h0);
    wr(OFS_TAR, 32'hffffe025);
    rd(OFS_TAR, 32'h025);
    lk_wait();
    chk("lk_master_addr", lk_master_addr, 32'h025);
    chk("lk_master_ten", lk_master_ten, 32'h0);
    chk("lk_hs_byte", lk_hs_byte, 32'h0f);
    chk("lk_loopback", lk_loopback, 32'h1);
    sl(10'h025, 1'b0, 1'b1);
    sl(10'h025, 1'b1, 1'b0);
    agent.own(1'b1);
    sl(10'h025, 1'b0, 1'b0);
    agent.own(1'b0);
    wr(OFS_CON, 32'h08);
    lk_wait();
    sl(10'h025, 1'b1, 1'b0);
    sl(10'h3a5, 1'b1, 1'b1);
    sl(10'h3a5, 1'b0, 1'b0);
    wr(OFS_CON, 32'h49);
    lk_wait();
    chk("slave_off", slave_off, 32'h1);
    sl(10'h3a5, 1'b1, 1'b0);
    controller_enable <= 1'b1;
    master_active <= 1'b1;
    wr(OFS_CON, 32'h0);
    rd(OFS_CON, 32'h4f);
    wr(OFS_SAR, 32'h11);
    rd(OFS_SAR, 32'h3a5);
    wr(OFS_HS, 32'h2);
    rd(OFS_HS, 32'h7);
    wr(OFS_TAR, 32'h800);
    rd(OFS_TAR, 32'h025);
    master_active <= 1'b0;
    tx_fifo_empty <= 1'b0;
    wr(OFS_TAR, 32'h800);
    rd(OFS_TAR, 32'h025);
    tx_fifo_empty <= 1'b1;
    wr(OFS_TAR, 32'h800);
    rd(OFS_TAR, 32'h800);
    chk("prdata2", q2, 32'h025);
    wr(OFS_DATA, 32'h1a5);
    chk("abort", abrt, 32'h1);
    chk("tx_push", push, 32'h0);
    wr(OFS_DATA, 32'h0c3);
    chk("tx_push", push, 32'h1);
    chk("tx_entry", ent, 32'h0c3);
    lk_wait();
    chk("lk_master_addr", lk_master_addr, 32'h000);
    chk("lk_master_ten", lk_master_ten, 32'h0);
    wr(OFS_TAR, 32'hc00);
    lk_wait();
    chk("lk_master_addr", lk_master_addr, 32'h001);
    wr(OFS_DATA, 32'h1a5);
    chk("tx_push", push, 32'h1);
    chk("tx_entry", ent, 32'h100);
    rd_req_seen <= 1'b1;
    wr(OFS_DATA, 32'h101);
    chk("abort", abrt, 32'h1);
    rd_req_seen <= 1'b0;
    tx_fifo_full <= 1'b1;
    wr(OFS_DATA, 32'h07);
    chk("tx_push", push, 32'h0);
    tx_fifo_full <= 1'b0;
    rx_fifo_valid <= 1'b1;
    rd(OFS_DATA, 32'h5a);
    chk("rx_pop", pop, 32'h1);
    rd(8'h14, 32'h0);
    chk("pslverr", err, 32'h1);
    results();
  end
endmodule
`default_nettype wire
